// ---- src/ffaic_pkg.sv ----
package ffaic_pkg;
	// register offsets
	localparam logic [7:0] OFF_RATE  = 8'h44;
	localparam logic [7:0] OFF_QA    = 8'h48;
	localparam logic [7:0] OFF_QB    = 8'h49;
	localparam logic [7:0] OFF_STAT  = 8'h4a;
	localparam logic [7:0] OFF_SLV   = 8'h4b;
	localparam logic [7:0] OFF_SETUP = 8'h4c;
	localparam logic [7:0] OFF_RPTR  = 8'h4d;
	// values after reset
	localparam logic [7:0] RST_RATE  = 8'h46;
	localparam logic [7:0] RST_QA    = 8'h02;
	localparam logic [7:0] RST_QB    = 8'h10;
	localparam logic [7:0] RST_SLV   = 8'h20;
	localparam logic [7:0] RST_SETUP = 8'h83;
	localparam logic [7:0] RST_RPTR  = 8'h42;
	// writable bits; the rest read as zero
	localparam logic [7:0] MSK_QA    = 8'h03;
	localparam logic [7:0] MSK_QB    = 8'h7c;
	localparam logic [7:0] MSK_SLV   = 8'hfe;
	localparam logic [7:0] MSK_SETUP = 8'h83;
	// field positions
	localparam int B_STOP   = 0;
	localparam int B_TIME   = 1;
	localparam int B_TAG2   = 2;
	localparam int B_TAG1   = 3;
	localparam int B_HDR    = 4;
	localparam int B_AUX    = 5;
	localparam int B_ACC    = 6;
	localparam int B_MANUAL = 7;
	// frame header bits
	localparam int H_ACC  = 0;
	localparam int H_AUX  = 1;
	localparam int H_TAG1 = 2;
	localparam int H_TAG2 = 3;
	localparam int H_MARK = 7;
	// burst lengths in bytes
	localparam logic [3:0] BURST_ONE_BYTE    = 4'h1;
	localparam logic [3:0] BURST_TWO_BYTES   = 4'h2;
	localparam logic [3:0] BURST_SIX_BYTES   = 4'h6;
	localparam logic [3:0] burst_eight_bytes = 4'h8;
	// poll rate codes that are usable
	localparam logic [3:0] ODR_MIN = 4'h1;
	localparam logic [3:0] ODR_MAX = 4'hb;
	// timing
	localparam int CLK_MHZ        = 250;
	localparam int OFFS_UNIT_US   = 2500;
	localparam int OFFS_UNIT_CYC  = OFFS_UNIT_US * CLK_MHZ;
	localparam int BASE_PERIOD_MS = 1280;
	localparam int BASE_PERIOD_CYC = BASE_PERIOD_MS * CLK_MHZ * 1000;
	localparam int I2C_BIT_NS     = 2500;
	localparam logic [7:0] I2C_Q_CYC = 8'((I2C_BIT_NS * CLK_MHZ + 3999) / 4000);

	// burst code to byte count
	function automatic logic [3:0] ffaic_burst_bytes(input logic [1:0] c);
		case (c)
			2'h0: return BURST_ONE_BYTE;
			2'h1: return BURST_TWO_BYTES;
			2'h2: return BURST_SIX_BYTES;
			default: return burst_eight_bytes;
		endcase
	endfunction
endpackage

// ---- src/ffaic_aux_if.sv ----
`timescale 1ns/100ps
interface ffaic_aux_if;
	logic        start;  // one-cycle burst request
	logic [6:0]  dev;    // slave address
	logic [7:0]  reg_a;  // first slave register
	logic [3:0]  nbytes; // burst length
	logic        busy;   // burst in flight
	logic        done;   // one-cycle end of burst
	logic        nack;   // slave refused
	logic [63:0] data;   // bytes, first in low lane
	logic        scl_i;
	logic        sda_i;
	logic        scl_o;
	logic        sda_o;
	logic        scl_oe;
	logic        sda_oe;
	modport ctl (output start, dev, reg_a, nbytes, scl_i, sda_i,
		input busy, done, nack, data, scl_o, sda_o, scl_oe, sda_oe);
	modport eng (input start, dev, reg_a, nbytes, scl_i, sda_i,
		output busy, done, nack, data, scl_o, sda_o, scl_oe, sda_oe);
endinterface

// ---- src/ffaic_side_master.sv ----
`timescale 1ns/100ps
// open-drain burst reader: start, addr+w, reg, restart, addr+r, bytes, stop
module ffaic_side_master
	import ffaic_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset,
	// controller side
	ffaic_aux_if.eng aux
);
	typedef enum logic [2:0] {S_IDLE, S_START, S_TX, S_RX, S_STOP} ffaic_ms_t;
	typedef struct packed {
		ffaic_ms_t   st;
		logic [7:0]  q;      // quarter-bit timer
		logic [1:0]  ph;     // quarter within bit
		logic [3:0]  bn;     // bit number, 8 is ack
		logic [7:0]  sh;     // shift byte
		logic [1:0]  step;   // 0 addr+w, 1 reg, 2 addr+r
		logic [3:0]  cnt;    // bytes received
		logic [63:0] data;
		logic        scl_oe;
		logic        sda_oe;
		logic        busy;
		logic        done;
		logic        nack;
	} ffaic_ms_st_t;
	ffaic_ms_st_t s_ff, nxt_s;
	logic tick;

	////////////////////////////////////////////////////////////
	// bit engine; pins only ever pulled low, never driven high
	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.done = 1'b0;
		tick = (s_ff.q == I2C_Q_CYC - 8'h01);
		nxt_s.q = (s_ff.st == S_IDLE || tick) ? 8'h00 : s_ff.q + 8'h01;
		if (s_ff.st == S_IDLE)
		begin
			if (aux.start)
			begin
				nxt_s.st = S_START;
				nxt_s.busy = 1'b1;
				nxt_s.step = 2'h0;
				nxt_s.cnt = 4'h0;
				nxt_s.nack = 1'b0;
				nxt_s.ph = 2'h0;
				nxt_s.data = 64'h0;
			end
		end
		else if (tick)
		begin
			nxt_s.ph = s_ff.ph + 2'h1;
			case (s_ff.st)
				S_START:
					// also serves as repeated start with scl low
					case (s_ff.ph)
						2'h0: nxt_s.sda_oe = 1'b0;
						2'h1: nxt_s.scl_oe = 1'b0;
						2'h2: nxt_s.sda_oe = 1'b1;
						default:
						begin
							nxt_s.scl_oe = 1'b1;
							nxt_s.st = S_TX;
							nxt_s.bn = 4'h0;
							nxt_s.sh = {aux.dev, s_ff.step == 2'h2};
						end
					endcase
				S_TX:
					case (s_ff.ph)
						2'h0: nxt_s.sda_oe = (s_ff.bn == 4'h8) ? 1'b0 : !s_ff.sh[7];
						2'h1: nxt_s.scl_oe = 1'b0;
						2'h2: if (s_ff.bn == 4'h8 && aux.sda_i) nxt_s.nack = 1'b1;
						default:
						begin
							nxt_s.scl_oe = 1'b1;
							nxt_s.bn = s_ff.bn + 4'h1;
							nxt_s.sh = {s_ff.sh[6:0], 1'b0};
							if (s_ff.bn == 4'h8)
							begin
								nxt_s.bn = 4'h0;
								// a refused byte ends the burst at once
								if (s_ff.nack)
									nxt_s.st = S_STOP;
								else if (s_ff.step == 2'h0)
								begin
									nxt_s.step = 2'h1;
									nxt_s.sh = aux.reg_a;
								end
								else if (s_ff.step == 2'h1)
								begin
									nxt_s.step = 2'h2;
									nxt_s.st = S_START;
								end
								else
									nxt_s.st = S_RX;
							end
						end
					endcase
				S_RX:
					case (s_ff.ph)
						// ack every byte but the last
						2'h0: nxt_s.sda_oe = (s_ff.bn == 4'h8) && (s_ff.cnt != aux.nbytes - 4'h1);
						2'h1: nxt_s.scl_oe = 1'b0;
						2'h2: if (s_ff.bn != 4'h8) nxt_s.sh = {s_ff.sh[6:0], aux.sda_i};
						default:
						begin
							nxt_s.scl_oe = 1'b1;
							nxt_s.bn = s_ff.bn + 4'h1;
							if (s_ff.bn == 4'h8)
							begin
								nxt_s.data[{s_ff.cnt[2:0], 3'b000} +: 8] = s_ff.sh;
								nxt_s.cnt = s_ff.cnt + 4'h1;
								nxt_s.bn = 4'h0;
								if (s_ff.cnt == aux.nbytes - 4'h1) nxt_s.st = S_STOP;
							end
						end
					endcase
				default:
					case (s_ff.ph)
						2'h0: nxt_s.sda_oe = 1'b1;
						2'h1: nxt_s.scl_oe = 1'b0;
						2'h2: nxt_s.sda_oe = 1'b0;
						default:
						begin
							nxt_s.st = S_IDLE;
							nxt_s.busy = 1'b0;
							nxt_s.done = 1'b1;
						end
					endcase
			endcase
		end
	end

	// state register
	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
			s_ff <= '{st: S_IDLE, default: '0};
		else
			s_ff <= nxt_s;
	end

	assign aux.busy   = s_ff.busy;
	assign aux.done   = s_ff.done;
	assign aux.nack   = s_ff.nack;
	assign aux.data   = s_ff.data;
	assign aux.scl_oe = s_ff.scl_oe;
	assign aux.sda_oe = s_ff.sda_oe;
	assign aux.scl_o  = 1'b0;
	assign aux.sda_o  = 1'b0;
endmodule // ffaic_side_master

// ---- src/ffaic_top.sv ----
// Design decision made here: strobed register access.
`timescale 1ns/100ps
module ffaic_top
	import ffaic_pkg::*;
#(
	parameter int unsigned P_OFFS_UNIT_CYC   = OFFS_UNIT_CYC,
	parameter int unsigned P_BASE_PERIOD_CYC = BASE_PERIOD_CYC
)
(
	// clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_reset,
	// register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rd_data,
	// sample sources
	input  wire logic        i_acc_valid,
	input  wire logic [47:0] i_acc_data,
	input  wire logic        i_irq1,
	input  wire logic        i_irq2,
	// queue side
	input  wire logic        i_q_full,
	input  wire logic        i_rd_last,
	output logic             o_frm_valid,
	output logic      [7:0]  o_frm_hdr,
	output logic      [47:0] o_frm_acc,
	output logic      [63:0] o_frm_aux,
	output logic             o_frm_drop_old,
	output logic             o_time_frame,
	// side bus pins
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output logic             o_scl,
	output logic             o_scl_oe,
	output logic             o_sda,
	output logic             o_sda_oe
);
	typedef struct packed {
		logic [7:0]  qa;      // first queue control
		logic [7:0]  qb;      // second queue control
		logic [7:0]  slv;     // slave address
		logic [7:0]  setup;   // mode and burst
		logic [7:0]  rptr;    // slave read pointer
		logic [7:0]  rate;    // offset and poll rate
		logic [7:0]  rdata;   // read answer
		logic [31:0] per;     // poll period timer
		logic [31:0] dly;     // trigger to readout delay
		logic        dly_on;
		logic        start;
		logic [63:0] auxd;    // last aux burst
		logic        aux_new;
		logic        ovr;     // sample lost to a full queue
		logic        fv;
		logic [7:0]  fh;
		logic [47:0] fa;
		logic [63:0] fx;
		logic        drop;
		logic        tfr;
	} ffaic_st_t;

	localparam ffaic_st_t ST_RST = '{qa: RST_QA, qb: RST_QB, slv: RST_SLV,
		setup: RST_SETUP, rptr: RST_RPTR, rate: RST_RATE, default: '0};

	ffaic_st_t   s_ff, nxt_s;
	ffaic_aux_if aux ();
	logic [3:0]  odr;       // poll rate code
	logic [31:0] period;    // poll period in cycles
	logic        poll_ok;   // data mode and a usable rate
	logic        aux_fresh; // burst landed this cycle
	logic        go;        // a frame is due
	logic        has_aux;

	////////////////////////////////////////////////////////////
	// side bus engine
	ffaic_side_master u_master (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.aux        (aux.eng)
	);

	assign aux.start  = s_ff.start;
	assign aux.dev    = s_ff.slv[7:1];
	assign aux.reg_a  = s_ff.rptr;
	assign aux.nbytes = ffaic_burst_bytes(s_ff.setup[1:0]);
	assign aux.scl_i  = i_scl;
	assign aux.sda_i  = i_sda;

	////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		nxt_s = s_ff;
		// pulses default low
		nxt_s.rdata = 8'h00;
		nxt_s.start = 1'b0;
		nxt_s.fv = 1'b0;
		nxt_s.drop = 1'b0;
		nxt_s.tfr = 1'b0;

		// register writes, reserved bits masked off
		if (i_wr)
		begin
			if (i_addr == OFF_QA)
				nxt_s.qa = i_wdata & MSK_QA;
			else if (i_addr == OFF_QB)
				nxt_s.qb = i_wdata & MSK_QB;
			else if (i_addr == OFF_SLV)
				nxt_s.slv = i_wdata & MSK_SLV;
			else if (i_addr == OFF_SETUP)
				nxt_s.setup = i_wdata & MSK_SETUP;
			else if (i_addr == OFF_RPTR)
				nxt_s.rptr = i_wdata;
			else if (i_addr == OFF_RATE)
				nxt_s.rate = i_wdata;
		end

		// register reads; unmapped reads give zero
		if (i_rd)
		begin
			if (i_addr == OFF_QA)
				nxt_s.rdata = s_ff.qa;
			else if (i_addr == OFF_QB)
				nxt_s.rdata = s_ff.qb;
			else if (i_addr == OFF_SLV)
				nxt_s.rdata = s_ff.slv;
			else if (i_addr == OFF_SETUP)
				nxt_s.rdata = s_ff.setup;
			else if (i_addr == OFF_RPTR)
				nxt_s.rdata = s_ff.rptr;
			else if (i_addr == OFF_RATE)
				nxt_s.rdata = s_ff.rate;
			else if (i_addr == OFF_STAT)
			begin
				// reading clears the overrun flag; a new loss below wins
				nxt_s.rdata = {4'h0, s_ff.aux_new, aux.nack, aux.busy, s_ff.ovr};
				nxt_s.ovr = 1'b0;
			end
		end

		// poll timer: reserved rate codes or setup mode stop it
		odr = s_ff.rate[3:0];
		poll_ok = !s_ff.setup[B_MANUAL] && odr >= ODR_MIN && odr <= ODR_MAX;
		period = P_BASE_PERIOD_CYC >> (odr - 4'h1);
		if (!poll_ok)
		begin
			nxt_s.per = 32'h0;
			nxt_s.dly_on = 1'b0;
		end
		else if (s_ff.per >= period - 32'h1)
		begin
			// trigger: arm the readout delay
			nxt_s.per = 32'h0;
			nxt_s.dly_on = 1'b1;
			nxt_s.dly = 32'(s_ff.rate[7:4]) * P_OFFS_UNIT_CYC;
		end
		else
			nxt_s.per = s_ff.per + 32'h1;

		// readout launch; waits while an earlier burst is in flight
		if (poll_ok && s_ff.dly_on)
		begin
			if (s_ff.dly != 32'h0)
				nxt_s.dly = s_ff.dly - 32'h1;
			else if (!aux.busy && !s_ff.start)
			begin
				nxt_s.start = 1'b1;
				nxt_s.dly_on = 1'b0;
			end
		end

		// keep the latest good burst
		aux_fresh = aux.done && !aux.nack;
		if (aux_fresh)
		begin
			nxt_s.auxd = aux.data;
			nxt_s.aux_new = 1'b1;
		end

		// frame build: aux rides with the next accel sample when both are on
		go = (i_acc_valid && s_ff.qb[B_ACC]) ||
			(aux_fresh && s_ff.qb[B_AUX] && !s_ff.qb[B_ACC]);
		has_aux = s_ff.qb[B_AUX] && (s_ff.aux_new || aux_fresh);
		if (go)
		begin
			if (i_q_full && s_ff.qa[B_STOP])
				nxt_s.ovr = 1'b1;
			else
			begin
				nxt_s.fv = 1'b1;
				nxt_s.drop = i_q_full;
				nxt_s.aux_new = 1'b0;
			end
			nxt_s.fh = 8'h00;
			nxt_s.fh[H_MARK] = s_ff.qb[B_HDR];
			nxt_s.fh[H_ACC] = s_ff.qb[B_ACC];
			nxt_s.fh[H_AUX] = has_aux;
			nxt_s.fh[H_TAG1] = s_ff.qb[B_TAG1] && i_irq1;
			nxt_s.fh[H_TAG2] = s_ff.qb[B_TAG2] && i_irq2;
			nxt_s.fa = s_ff.qb[B_ACC] ? i_acc_data : 48'h0;
			nxt_s.fx = has_aux ? (aux_fresh ? aux.data : s_ff.auxd) : 64'h0;
		end

		// time frame after the last valid data frame is read
		if (i_rd_last && s_ff.qa[B_TIME])
			nxt_s.tfr = 1'b1;
	end

	// state register
	always_ff @(posedge i_core_clk or posedge i_reset)
	begin
		if (i_reset)
			s_ff <= ST_RST;
		else
			s_ff <= nxt_s;
	end

	// outputs straight from state
	assign o_rd_data      = s_ff.rdata;
	assign o_frm_valid    = s_ff.fv;
	assign o_frm_hdr      = s_ff.fh;
	assign o_frm_acc      = s_ff.fa;
	assign o_frm_aux      = s_ff.fx;
	assign o_frm_drop_old = s_ff.drop;
	assign o_time_frame   = s_ff.tfr;
	assign o_scl          = aux.scl_o;
	assign o_scl_oe       = aux.scl_oe;
	assign o_sda          = aux.sda_o;
	assign o_sda_oe       = aux.sda_oe;

	////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	// write, one quiet cycle, then read back; the quiet cycle keeps the
	// written value the one that the read must return
	sequence s_qa_wr_rd;
		(i_wr && i_addr == OFF_QA) ##1 !i_wr ##1 (i_rd && i_addr == OFF_QA);
	endsequence
	property p_qa_rsv;
		s_qa_wr_rd |=> o_rd_data == ($past(i_wdata, 3) & MSK_QA);
	endproperty
	a_qa_rsv: assert property (p_qa_rsv) else $error("first control readback wrong");

	property p_rst_vals;
		$past(i_reset) |-> s_ff.qa == 8'h02 && s_ff.qb == 8'h10 && s_ff.slv == 8'h20
			&& s_ff.setup == 8'h83 && s_ff.rptr == 8'h42;
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("reset value wrong");

	property p_stop_full;
		go && i_q_full && s_ff.qa[B_STOP] |=> !o_frm_valid && s_ff.ovr;
	endproperty
	a_stop_full: assert property (p_stop_full) else $error("stored into full queue");

	property p_drop_old;
		go && i_q_full && !s_ff.qa[B_STOP] |=> o_frm_valid && o_frm_drop_old;
	endproperty
	a_drop_old: assert property (p_drop_old) else $error("no overwrite when full");

	property p_time_frame;
		i_rd_last |=> o_time_frame == $past(s_ff.qa[B_TIME]);
	endproperty
	a_time_frame: assert property (p_time_frame) else $error("time frame wrong");

	property p_tag2;
		go |=> o_frm_hdr[H_TAG2] == ($past(s_ff.qb[B_TAG2]) && $past(i_irq2));
	endproperty
	a_tag2: assert property (p_tag2) else $error("irq two tag wrong");

	property p_tag1;
		go |=> o_frm_hdr[H_TAG1] == ($past(s_ff.qb[B_TAG1]) && $past(i_irq1));
	endproperty
	a_tag1: assert property (p_tag1) else $error("irq one tag wrong");

	property p_no_aux;
		go && !s_ff.qb[B_AUX] |=> o_frm_aux == 64'h0;
	endproperty
	a_no_aux: assert property (p_no_aux) else $error("aux stored while off");

	property p_acc;
		go && s_ff.qb[B_ACC] |=> o_frm_acc == $past(i_acc_data);
	endproperty
	a_acc: assert property (p_acc) else $error("accel axes lost");

	property p_burst8;
		s_ff.setup[1:0] == 2'h3 |-> aux.nbytes == 4'h8;
	endproperty
	a_burst8: assert property (p_burst8) else $error("burst length wrong");

	property p_setup_quiet;
		s_ff.setup[B_MANUAL] && $past(s_ff.setup[B_MANUAL]) |-> !s_ff.start;
	endproperty
	a_setup_quiet: assert property (p_setup_quiet) else $error("polled in setup mode");

	property p_aux_frame;
		aux_fresh && s_ff.qb[B_AUX] && !s_ff.qb[B_ACC] && !i_q_full
			|=> o_frm_valid && o_frm_aux == $past(aux.data);
	endproperty
	a_aux_frame: assert property (p_aux_frame) else $error("aux burst not queued");
endmodule // ffaic_top

// ---- test/ffaic_slave_model.sv ----
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// behavioural side-bus slave: acks its own address, takes a register pointer
// and returns pattern bytes (pointer xor 0x5a), stepping the pointer per byte
module ffaic_slave_model
#(
	parameter logic [6:0] P_DEV = 7'h1d // own bus address, arbitrary
)
(
	// resolved bus wires
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	// open-drain pull and observation
	output logic            o_sda_oe,
	output logic      [7:0] o_reg_seen
);
	int         bitn  = 0;     // clocks seen in this byte, 9 after the ack clock
	logic       act   = 1'b0;  // addressed and taking part
	logic       first = 1'b0;  // next byte is an address byte
	logic       rd_m  = 1'b0;  // slave is sending
	logic [7:0] sh    = 8'h00; // incoming shift register
	logic [7:0] ptr   = 8'h00; // register pointer
	logic [7:0] out   = 8'h00; // byte on its way out
	initial o_sda_oe = 1'b0;
	initial o_reg_seen = 8'h00;
	////////////////////////////////////////////////////////////////////////////
	// start and repeated start: data falls while clock is high
	always @(negedge i_sda)
		if (i_scl === 1'b1)
		begin
			act   = 1'b1;
			first = 1'b1;
			rd_m  = 1'b0;
			bitn  = 0;
		end
	// stop: data rises while clock is high, line released
	always @(posedge i_sda)
		if (i_scl === 1'b1)
		begin
			act      = 1'b0;
			o_sda_oe = 1'b0;
		end
	////////////////////////////////////////////////////////////////////////////
	// sample on the rising clock; a master nack ends the read
	always @(posedge i_scl)
	begin
		if (bitn < 8 && !rd_m)
			sh = {sh[6:0], i_sda};
		if (bitn == 8 && rd_m && i_sda)
			act = 1'b0;
		bitn = bitn + 1;
	end
	// drive only while the clock is low so no false start or stop is made
	always @(negedge i_scl)
	begin
		o_sda_oe = 1'b0;
		if (bitn == 9)
			bitn = 0;
		if (act && bitn == 8 && !rd_m)
		begin
			// ack slot after an address or pointer byte
			if (first)
			begin
				act  = (sh[7:1] == P_DEV);
				rd_m = sh[0] && act;
			end
			else
			begin
				ptr        = sh;
				o_reg_seen = sh;
			end
			first    = 1'b0;
			o_sda_oe = act;
		end
		else if (act && rd_m && bitn < 8)
		begin
			// msb first; a one releases the line
			if (bitn == 0)
			begin
				out = ptr ^ 8'h5a;
				ptr = ptr + 8'h01;
			end
			o_sda_oe = !out[7 - bitn];
		end
	end
endmodule // ffaic_slave_model

// ---- test/fifo_frame_and_aux_if_config_tb.sv ----
`timescale 1ns/100ps
module fifo_frame_and_aux_if_config_tb
	import ffaic_pkg::*;
;
	// clock, reset and register port
	logic        i_core_clk = 1'b0;
	logic        i_reset    = 1'b1;
	logic [7:0]  i_addr     = 8'h00;
	logic [7:0]  i_wdata    = 8'h00;
	logic        i_wr       = 1'b0;
	logic        i_rd       = 1'b0;
	logic [7:0]  o_rd_data;
	// sample sources and queue side
	logic        i_acc_valid = 1'b0;
	logic [47:0] i_acc_data  = 48'h0;
	logic        i_irq1      = 1'b0;
	logic        i_irq2      = 1'b0;
	logic        i_q_full    = 1'b0;
	logic        i_rd_last   = 1'b0;
	logic        o_frm_valid, o_frm_drop_old, o_time_frame;
	logic [7:0]  o_frm_hdr;
	logic [47:0] o_frm_acc;
	logic [63:0] o_frm_aux;
	// side bus wires, both pulled up
	logic        o_scl, o_scl_oe, o_sda, o_sda_oe, slv_oe, scl_w, sda_w;
	logic [7:0]  reg_seen;
	int          fail_count = 0;
	int          tests_run  = 0;
	// register table: offset, reset value, read-back after writing all ones
	localparam logic [7:0] REG_OFF [6] = '{OFF_RATE, OFF_QA, OFF_QB, OFF_SLV, OFF_SETUP, OFF_RPTR};
	localparam logic [7:0] REG_RST [6] = '{8'h46, 8'h02, 8'h10, 8'h20, 8'h83, 8'h42};
	localparam logic [7:0] REG_ONE [6] = '{8'hff, 8'h03, 8'h7c, 8'hfe, 8'h83, 8'hff};
	always #2 i_core_clk = ~i_core_clk;
	assign scl_w = (o_scl_oe && !o_scl) ? 1'b0 : 1'b1;
	assign sda_w = ((o_sda_oe && !o_sda) || slv_oe) ? 1'b0 : 1'b1;
	////////////////////////////////////////////////////////////////////////////
	// short counts so a poll period is 64 cycles and an offset unit 4
	ffaic_top #(.P_OFFS_UNIT_CYC(4), .P_BASE_PERIOD_CYC(64)) dut_u (
		.i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_acc_valid(i_acc_valid),
		.i_acc_data(i_acc_data), .i_irq1(i_irq1), .i_irq2(i_irq2), .i_q_full(i_q_full),
		.i_rd_last(i_rd_last), .o_frm_valid(o_frm_valid), .o_frm_hdr(o_frm_hdr),
		.o_frm_acc(o_frm_acc), .o_frm_aux(o_frm_aux), .o_frm_drop_old(o_frm_drop_old),
		.o_time_frame(o_time_frame), .i_scl(scl_w), .i_sda(sda_w), .o_scl(o_scl),
		.o_scl_oe(o_scl_oe), .o_sda(o_sda), .o_sda_oe(o_sda_oe));
	ffaic_slave_model #(.P_DEV(7'h1d)) slave_u (.i_scl(scl_w), .i_sda(sda_w),
		.o_sda_oe(slv_oe), .o_reg_seen(reg_seen));
	////////////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// verdict and end of run
	task automatic results();
		$display("counts: %0d checks, %0d mismatches", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// a bounded wait ran out
	task automatic give_up(input string what);
		fail_count++;
		$display("mismatch %s expected done seen timeout", what);
		results();
	endtask
	////////////////////////////////////////////////////////////////////////////
	// register port: one-cycle strobes, read data stands in the following cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_core_clk);
		i_wr    <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_core_clk);
		i_rd   <= 1'b0;
		#1 d = o_rd_data;
	endtask
	// one accel sample; irq holds {irq two, irq one}
	task automatic acc_frame(input logic [7:0] qa, input logic [7:0] qb, input logic full,
		input logic [1:0] irq, input logic v_exp);
		logic [47:0] d;
		d = 48'h1234_5678_9a00 | {40'h0, qb};
		wr(OFF_QA, qa);
		wr(OFF_QB, qb);
		@(posedge i_core_clk);
		i_acc_valid <= 1'b1;
		i_acc_data  <= d;
		i_q_full    <= full;
		{i_irq2, i_irq1} <= irq;
		@(posedge i_core_clk);
		i_acc_valid <= 1'b0;
		#1;
		chk("frame valid", o_frm_valid, v_exp);
		if (v_exp)
		begin
			chk("frame header", o_frm_hdr, {qb[4], 3'h0, qb[2] & irq[1], qb[3] & irq[0], 2'h1});
			chk("frame accel", o_frm_acc, d);
			chk("drop oldest", o_frm_drop_old, full && !qa[0]);
		end
	endtask
	// host read of the last frame
	task automatic time_frame(input logic [7:0] qa, input logic exp);
		wr(OFF_QA, qa);
		@(posedge i_core_clk);
		i_rd_last <= 1'b1;
		@(posedge i_core_clk);
		i_rd_last <= 1'b0;
		#1 chk("time frame", o_time_frame, exp);
	endtask
	// poll with a burst code, then leave data mode once the burst is under way
	// so that no second burst follows it and the run stays short
	task automatic aux_burst(input logic [1:0] code);
		logic [63:0] exp;
		logic [7:0]  s;
		int          n;
		int          t;
		n   = (code == 2'h0) ? 1 : (code == 2'h1) ? 2 : (code == 2'h2) ? 6 : 8;
		exp = 64'h0;
		for (int k = 0; k < n; k++)
			exp[8*k +: 8] = (8'h37 + 8'(k)) ^ 8'h5a;
		wr(OFF_SETUP, {6'h00, code});
		for (t = 0; t < 1000; t++)
		begin
			rd(OFF_STAT, s);
			if (s[1] === 1'b1)
				break;
		end
		if (t == 1000)
			give_up("side bus start");
		wr(OFF_SETUP, {6'h20, code});
		for (t = 0; t < 90000; t++)
		begin
			@(posedge i_core_clk);
			#1;
			if (o_frm_valid === 1'b1)
				break;
		end
		if (t == 90000)
			give_up("aux frame");
		chk("aux bytes", o_frm_aux, exp);
		chk("aux header", o_frm_hdr, 8'h82);
		chk("slave pointer", reg_seen, 8'h37);
		chk("open drain levels", {o_scl, o_sda}, 2'h0);
		// setup mode: no further poll, no refusal, aux data consumed
		rd(OFF_STAT, s);
		chk("side bus status", s[3:1], 3'h0);
	endtask
	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		logic [7:0] v;
		repeat (2) @(posedge i_core_clk);
		i_reset <= 1'b0;
		// reset values, writable bits, cleared bits
		for (int k = 0; k < 6; k++)
		begin
			rd(REG_OFF[k], v);
			chk("reset value", v, REG_RST[k]);
			wr(REG_OFF[k], 8'hff);
			rd(REG_OFF[k], v);
			chk("all ones", v, REG_ONE[k]);
			wr(REG_OFF[k], 8'h00);
			rd(REG_OFF[k], v);
			chk("all zeros", v, 8'h00);
		end
		wr(8'h50, 8'hff);
		rd(8'h50, v);
		chk("unmapped", v, 8'h00);
		$display("test registers done");
		// every tag and header setting against both interrupt states
		for (int k = 0; k < 16; k++)
			acc_frame(8'h00, {3'h2, 3'(k), 2'h0}, 1'b0, k[3] ? 2'h1 : 2'h2, 1'b1);
		acc_frame(8'h00, 8'h10, 1'b0, 2'h3, 1'b0);
		$display("test frames done");
		// full queue with and without stop
		acc_frame(8'h01, 8'h50, 1'b1, 2'h0, 1'b0);
		rd(OFF_STAT, v);
		chk("overrun", v[0], 1'b1);
		rd(OFF_STAT, v);
		chk("overrun cleared", v[0], 1'b0);
		acc_frame(8'h00, 8'h50, 1'b1, 2'h0, 1'b1);
		acc_frame(8'h01, 8'h50, 1'b0, 2'h0, 1'b1);
		$display("test full queue done");
		time_frame(8'h02, 1'b1);
		time_frame(8'h01, 1'b0);
		$display("test time frame done");
		// side bus polling in data mode, shortest and longest burst
		wr(OFF_SLV, 8'h3a);
		wr(OFF_RPTR, 8'h37);
		wr(OFF_QA, 8'h00);
		wr(OFF_QB, 8'h30);
		wr(OFF_RATE, 8'h11);
		aux_burst(2'h0);
		aux_burst(2'h3);
		$display("test side bus done");
		results();
	end
endmodule // fifo_frame_and_aux_if_config_tb
